//--- hw/tx_cfg_regs.sv
// transmitter configuration registers behind the serial register port
`timescale 1ns/1ps
`default_nettype none
module tx_cfg_regs
  import tx_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  input wire logic fifo_bit,
  input wire logic general_output_pin_zero,
  input wire logic frame_start,
  input wire logic [7:0] length_byte,
  output logic [7:0] sync_low_word,
  output logic [7:0] node_address,
  output logic [7:0] channel_index,
  output logic [23:0] base_frequency_word,
  output logic [CARRIER_W-1:0] carrier_word,
  output logic whitening_on,
  output logic crc_on,
  output logic [1:0] tx_data_source_format,
  output logic [1:0] length_mode,
  output logic [7:0] packet_length,
  output logic length_over,
  output logic length_unlimited,
  output logic symbol_tick,
  output logic tx_bit
);
  logic [7:0] cfg_ff [NUM_REGS];
  logic [7:0] nxt_cfg [NUM_REGS];
  logic sclk_q_ff, nxt_sclk_q;
  logic [2:0] bit_count_ff, nxt_bit_count;
  logic [7:0] shift_in_ff, nxt_shift_in;
  logic [7:0] shift_out_ff, nxt_shift_out;
  logic header_done_ff, nxt_header_done;
  logic read_ff, nxt_read;
  logic burst_ff, nxt_burst;
  logic [5:0] address_ff, nxt_address;
  logic miso_ff, nxt_miso;
  logic wr_en;
  logic [7:0] wr_data;
  logic sclk_rise, sclk_fall;
  logic [7:0] packet_length_ff, nxt_packet_length;
  logic length_over_ff, nxt_length_over;
  logic length_unlimited_ff, nxt_length_unlimited;
  logic [CARRIER_W-1:0] carrier_ff, nxt_carrier;
  logic tx_bit_ff, nxt_tx_bit;
  logic rate_tick, noise_bit;
  tx_data_source_format_t source;
  length_mode_t mode;

  // value seen by a read; fixed bits override stored ones
  function automatic logic [7:0] read_value(input logic [5:0] where);
    logic [7:0] value;
    value = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (where == REG_OFFSET[i]) begin
        value = (cfg_ff[i] & REG_WMASK[i]) | REG_RFIXED[i];
      end
    end
    return value;
  endfunction

  assign sclk_rise = sclk && !sclk_q_ff;
  assign sclk_fall = !sclk && sclk_q_ff;
  assign source = tx_data_source_format_t'(
    cfg_ff[SLOT_PACKET_CTRL][FORMAT_LSB +: 2]);
  assign mode = length_mode_t'(cfg_ff[SLOT_PACKET_CTRL][LENGTH_LSB +: 2]);

  // serial port: header byte then data bytes, msb first
  always_comb begin
    nxt_sclk_q = sclk;
    nxt_bit_count = bit_count_ff;
    nxt_shift_in = shift_in_ff;
    nxt_shift_out = shift_out_ff;
    nxt_header_done = header_done_ff;
    nxt_read = read_ff;
    nxt_burst = burst_ff;
    nxt_address = address_ff;
    nxt_miso = miso_ff;
    wr_en = 1'b0;
    wr_data = '0;
    if (cs_n) begin
      nxt_bit_count = '0;
      nxt_header_done = 1'b0;
      nxt_miso = 1'b0;
    end else if (sclk_rise) begin
      nxt_shift_in = {shift_in_ff[6:0], mosi};
      nxt_bit_count = bit_count_ff + 3'h1;
      if (bit_count_ff == BYTE_LAST_BIT) begin
        if (!header_done_ff) begin
          nxt_header_done = 1'b1;
          nxt_read = nxt_shift_in[HDR_READ_BIT];
          nxt_burst = nxt_shift_in[HDR_BURST_BIT];
          nxt_address = nxt_shift_in[5:0];
          nxt_shift_out = read_value(nxt_shift_in[5:0]);
        end else begin
          wr_en = !read_ff;
          wr_data = nxt_shift_in;
          // burst steps the address by one per data byte so consecutive registers load in one access
          if (burst_ff) begin
            nxt_address = address_ff + ADDRESS_STEP;
          end
          nxt_shift_out = read_value(nxt_address);
        end
      end
    end else if (sclk_fall) begin
      nxt_miso = shift_out_ff[7];
      nxt_shift_out = {shift_out_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q_ff <= 1'b0;
      bit_count_ff <= '0;
      shift_in_ff <= '0;
      shift_out_ff <= '0;
      header_done_ff <= 1'b0;
      read_ff <= 1'b0;
      burst_ff <= 1'b0;
      address_ff <= '0;
      miso_ff <= 1'b0;
    end else begin
      sclk_q_ff <= nxt_sclk_q;
      bit_count_ff <= nxt_bit_count;
      shift_in_ff <= nxt_shift_in;
      shift_out_ff <= nxt_shift_out;
      header_done_ff <= nxt_header_done;
      read_ff <= nxt_read;
      burst_ff <= nxt_burst;
      address_ff <= nxt_address;
      miso_ff <= nxt_miso;
    end
  end

  // register writes through per-register masks
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      nxt_cfg[i] = cfg_ff[i];
      if (wr_en && address_ff == REG_OFFSET[i]) begin
        nxt_cfg[i] = wr_data & REG_WMASK[i];
      end
    end
    if (wr_en && address_ff == REG_OFFSET[SLOT_PACKET_CTRL]
        && wr_data[LENGTH_LSB +: 2] == LEN_RESERVED) begin
      nxt_cfg[SLOT_PACKET_CTRL][LENGTH_LSB +: 2] =
        cfg_ff[SLOT_PACKET_CTRL][LENGTH_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_ff[i] <= REG_RESET[i];
      end
    end else begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_ff[i] <= nxt_cfg[i];
      end
    end
  end

  // packet length for the frame, sampled at frame start
  always_comb begin
    nxt_packet_length = packet_length_ff;
    nxt_length_over = length_over_ff;
    nxt_length_unlimited = length_unlimited_ff;
    if (frame_start) begin
      nxt_length_over = 1'b0;
      nxt_length_unlimited = 1'b0;
      nxt_packet_length = cfg_ff[SLOT_PACKET_LENGTH];
      unique case (mode)
        LEN_FIXED: begin
        end
        LEN_VARIABLE: begin
          nxt_packet_length = length_byte;
          nxt_length_over = length_byte > cfg_ff[SLOT_PACKET_LENGTH];
        end
        LEN_UNLIMITED: nxt_length_unlimited = 1'b1;
        LEN_RESERVED: begin
        end
      endcase
    end
  end

  // carrier word, base plus channel offset
  always_comb begin
    nxt_carrier = CARRIER_W'({cfg_ff[SLOT_FREQUENCY_HIGH],
      cfg_ff[SLOT_FREQUENCY_MID], cfg_ff[SLOT_FREQUENCY_LOW]})
      + CARRIER_W'(cfg_ff[SLOT_CHANNEL] * CHANNEL_SPACING_WORD);
  end

  // data bit selection; async mode bypasses the symbol clock
  always_comb begin
    nxt_tx_bit = tx_bit_ff;
    unique case (source)
      SRC_FIFO: if (rate_tick) begin
        nxt_tx_bit = fifo_bit ^ (whitening_on & noise_bit);
      end
      SRC_SERIAL_SYNC: if (rate_tick) begin
        nxt_tx_bit = general_output_pin_zero ^ (whitening_on & noise_bit);
      end
      SRC_PSEUDO_NOISE: if (rate_tick) begin
        nxt_tx_bit = noise_bit;
      end
      SRC_ASYNC: nxt_tx_bit = general_output_pin_zero;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      packet_length_ff <= '0;
      length_over_ff <= 1'b0;
      length_unlimited_ff <= 1'b0;
      carrier_ff <= '0;
      tx_bit_ff <= 1'b0;
    end else begin
      packet_length_ff <= nxt_packet_length;
      length_over_ff <= nxt_length_over;
      length_unlimited_ff <= nxt_length_unlimited;
      carrier_ff <= nxt_carrier;
      tx_bit_ff <= nxt_tx_bit;
    end
  end

  // symbol rate from mantissa and exponent
  symbol_rate_tick u_rate (
    .clk(clk),
    .rst_n(rst_n),
    .mantissa(cfg_ff[SLOT_RATE_MANTISSA]),
    .exponent(cfg_ff[SLOT_RATE_EXPONENT][EXPONENT_LSB +: 4]),
    .tick(rate_tick)
  );

  pseudo_noise_gen u_noise (
    .clk(clk),
    .rst_n(rst_n),
    .restart(frame_start),
    .advance(rate_tick && source != SRC_ASYNC),
    .noise_bit(noise_bit)
  );

  assign miso = miso_ff;
  assign sync_low_word = cfg_ff[SLOT_SYNC_LOW];
  assign node_address = cfg_ff[SLOT_NODE_ADDRESS];
  assign channel_index = cfg_ff[SLOT_CHANNEL];
  assign base_frequency_word = {cfg_ff[SLOT_FREQUENCY_HIGH],
    cfg_ff[SLOT_FREQUENCY_MID], cfg_ff[SLOT_FREQUENCY_LOW]};
  assign carrier_word = carrier_ff;
  assign whitening_on = cfg_ff[SLOT_PACKET_CTRL][WHITE_BIT];
  assign crc_on = cfg_ff[SLOT_PACKET_CTRL][CRC_BIT];
  assign tx_data_source_format = cfg_ff[SLOT_PACKET_CTRL][FORMAT_LSB +: 2];
  assign length_mode = cfg_ff[SLOT_PACKET_CTRL][LENGTH_LSB +: 2];
  assign packet_length = packet_length_ff;
  assign length_over = length_over_ff;
  assign length_unlimited = length_unlimited_ff;
  assign symbol_tick = rate_tick;
  assign tx_bit = tx_bit_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sync_write;
    wr_en && address_ff == REG_OFFSET[SLOT_SYNC_LOW];
  endsequence
  property p_sync_store;
    logic [7:0] d;
    (s_sync_write, d = wr_data) |=> sync_low_word == d;
  endproperty
  a_sync_store: assert property (p_sync_store)
    else $error("sync low byte not stored");
  property p_fixed_len;
    frame_start && mode == LEN_FIXED
      |=> packet_length == $past(cfg_ff[SLOT_PACKET_LENGTH]);
  endproperty
  a_fixed_len: assert property (p_fixed_len)
    else $error("fixed length not taken from setting");
  property p_var_over;
    frame_start && mode == LEN_VARIABLE
      && length_byte > cfg_ff[SLOT_PACKET_LENGTH] |=> length_over;
  endproperty
  a_var_over: assert property (p_var_over)
    else $error("length over maximum not flagged");
  property p_plain_fifo;
    rate_tick && source == SRC_FIFO && !whitening_on
      |=> tx_bit == $past(fifo_bit);
  endproperty
  a_plain_fifo: assert property (p_plain_fifo)
    else $error("unwhitened fifo bit altered");
  property p_noise_out;
    rate_tick && source == SRC_PSEUDO_NOISE |=> tx_bit == $past(noise_bit);
  endproperty
  a_noise_out: assert property (p_noise_out)
    else $error("noise pattern not sent");
  property p_async_out;
    source == SRC_ASYNC ##1 source == SRC_ASYNC
      |-> tx_bit == $past(general_output_pin_zero);
  endproperty
  a_async_out: assert property (p_async_out)
    else $error("async data not transparent");
  property p_no_reserved;
    mode != LEN_RESERVED;
  endproperty
  a_no_reserved: assert property (p_no_reserved)
    else $error("reserved length mode stored");
  // stored bits checked, so a broken write mask is caught
  property p_top_bits;
    base_frequency_word[23:22] == 2'h0;
  endproperty
  a_top_bits: assert property (p_top_bits)
    else $error("frequency top bits not zero");
  property p_upper_fixed;
    $stable(cfg_ff[SLOT_RATE_EXPONENT][7:4]);
  endproperty
  a_upper_fixed: assert property (p_upper_fixed)
    else $error("modulator upper nibble changed");
  property p_unused_zero;
    (cfg_ff[SLOT_PACKET_CTRL] & ~REG_WMASK[SLOT_PACKET_CTRL]) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused control bits not zero");
endmodule
`default_nettype wire

//--- pkg/tx_cfg_pkg.sv
// constants and types of the transmitter configuration register bank
// Notes on behaviour
// - sync word low byte register, resets 91h
// - fixed mode sends packet length setting bytes
// - variable mode: length setting is the maximum
// - whitening bit on whitens data, resets one
// - format 00 fifo, 01 serial pin zero
// - format 10 sends nine bit pseudo noise
// - format 11 transparent async data from pin
// - length mode 00 uses fixed length
// - length mode 01 takes first byte length
// - mode 10 unlimited, 11 reserved, resets 01
// - node address register resets zero, broadcast
// - channel times spacing added to base word
// - frequency word top two bits read zero
// - base frequency from 24-bit word, xtal/2^16
// - rate exponent low nibble, resets twelve
// - nine bit mantissa, hidden one, resets 22h
// - rate is (256+m)*2^e/2^28 times clock
// - modulator config upper nibble is read-only
package tx_cfg_pkg;
  localparam int NUM_REGS = 10;
  localparam int SLOT_SYNC_LOW = 0;
  localparam int SLOT_PACKET_LENGTH = 1;
  localparam int SLOT_PACKET_CTRL = 2;
  localparam int SLOT_NODE_ADDRESS = 3;
  localparam int SLOT_CHANNEL = 4;
  localparam int SLOT_FREQUENCY_HIGH = 5;
  localparam int SLOT_FREQUENCY_MID = 6;
  localparam int SLOT_FREQUENCY_LOW = 7;
  localparam int SLOT_RATE_EXPONENT = 8;
  localparam int SLOT_RATE_MANTISSA = 9;
  localparam logic [5:0] REG_OFFSET [NUM_REGS] = '{6'h05, 6'h06, 6'h08,
    6'h09, 6'h0A, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h11};
  localparam logic [7:0] REG_RESET [NUM_REGS] = '{8'h91, 8'hFF, 8'h45,
    8'h00, 8'h00, 8'h1E, 8'hC4, 8'hEC, 8'h0C, 8'h22};
  localparam logic [7:0] REG_WMASK [NUM_REGS] = '{8'hFF, 8'hFF, 8'h77,
    8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'h0F, 8'hFF};
  localparam logic [7:0] REG_RFIXED [NUM_REGS] = '{8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
  localparam int WHITE_BIT = 6;
  localparam int FORMAT_LSB = 4;
  localparam int CRC_BIT = 2;
  localparam int LENGTH_LSB = 0;
  localparam int EXPONENT_LSB = 0;
  localparam int HDR_READ_BIT = 7;
  localparam int HDR_BURST_BIT = 6;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [5:0] ADDRESS_STEP = 6'h01;
  localparam logic HIDDEN_ONE = 1'b1;
  localparam int RATE_PHASE_BITS = 28;
  localparam int RATE_ACC_W = RATE_PHASE_BITS + 1;
  localparam logic [15:0] CHANNEL_SPACING_WORD = 16'h0100;
  localparam int CARRIER_W = 25;
  localparam logic [8:0] NOISE_SEED = 9'h1FF;
  localparam int NOISE_TAP = 5;
  typedef enum logic [1:0] {
    SRC_FIFO, SRC_SERIAL_SYNC, SRC_PSEUDO_NOISE, SRC_ASYNC
  } tx_data_source_format_t;
  typedef enum logic [1:0] {
    LEN_FIXED, LEN_VARIABLE, LEN_UNLIMITED, LEN_RESERVED
  } length_mode_t;
endpackage

//--- hw/pseudo_noise_gen.sv
// nine bit pseudo noise sequence generator
`timescale 1ns/1ps
`default_nettype none
module pseudo_noise_gen
  import tx_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic advance,
  output logic noise_bit
);
  logic [8:0] lfsr_ff;
  logic [8:0] nxt_lfsr;

  always_comb begin
    nxt_lfsr = lfsr_ff;
    if (restart) begin
      nxt_lfsr = NOISE_SEED;
    end else if (advance) begin
      nxt_lfsr = {lfsr_ff[NOISE_TAP] ^ lfsr_ff[0], lfsr_ff[8:1]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_ff <= NOISE_SEED;
    end else begin
      lfsr_ff <= nxt_lfsr;
    end
  end

  assign noise_bit = lfsr_ff[0];
endmodule
`default_nettype wire

//--- hw/symbol_rate_tick.sv
// symbol rate phase accumulator, one tick per symbol
`timescale 1ns/1ps
`default_nettype none
module symbol_rate_tick
  import tx_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] mantissa,
  input wire logic [3:0] exponent,
  output logic tick
);
  logic [RATE_PHASE_BITS-1:0] phase_ff;
  logic [RATE_PHASE_BITS-1:0] nxt_phase;
  logic tick_ff;
  logic nxt_tick;
  logic [RATE_ACC_W-1:0] sum;

  always_comb begin
    sum = {1'b0, phase_ff}
      + (RATE_ACC_W'({HIDDEN_ONE, mantissa}) << exponent);
    nxt_phase = sum[RATE_PHASE_BITS-1:0];
    nxt_tick = sum[RATE_PHASE_BITS];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      phase_ff <= nxt_phase;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;
endmodule
`default_nettype wire

//--- verification/serial_host_model.sv
// host controller model driving the serial register port
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic sel(input logic on);
    hold(2);
    cs_n = !on;
    // released data line shows the inverse, never a stale bit
    if (!on) mosi = !mosi;
    hold(2);
  endtask
  // msb first; levels held three clk cycles since sclk is oversampled
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      hold(3);
      sclk = 1'b1;
      rx[i] = miso;
      hold(3);
      sclk = 1'b0;
    end
  endtask
  task automatic write_reg(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] r;
    sel(1'b1);
    xfer({2'b00, a}, r);
    xfer(d, r);
    sel(1'b0);
  endtask
  task automatic read_reg(input logic [5:0] a, output logic [7:0] d);
    logic [7:0] r;
    sel(1'b1);
    xfer({2'b10, a}, r);
    xfer(8'h00, d);
    sel(1'b0);
  endtask
endmodule
`default_nettype wire

//--- verification/test_tx_cfg_regs.sv
// self-checking bench of the transmitter configuration registers
`timescale 1ns/1ps
`default_nettype none
module test_tx_cfg_regs;
  import tx_cfg_pkg::*;
  logic clk, rst_n, cs_n, sclk, mosi, miso, fifo_bit, pin0, frame_start;
  logic [7:0] length_byte, sync_low_word, node_address, channel_index;
  logic [7:0] packet_length, rd;
  logic [23:0] base_frequency_word;
  logic [CARRIER_W-1:0] carrier_word;
  logic whitening_on, crc_on, length_over, length_unlimited;
  logic symbol_tick, tx_bit;
  logic [1:0] tx_data_source_format, length_mode;
  int err_count = 0;
  int samples_checked = 0;
  tx_cfg_regs DUT (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .miso(miso), .fifo_bit(fifo_bit),
    .general_output_pin_zero(pin0), .frame_start(frame_start),
    .length_byte(length_byte), .sync_low_word(sync_low_word),
    .node_address(node_address), .channel_index(channel_index),
    .base_frequency_word(base_frequency_word),
    .carrier_word(carrier_word), .whitening_on(whitening_on),
    .crc_on(crc_on), .tx_data_source_format(tx_data_source_format),
    .length_mode(length_mode), .packet_length(packet_length),
    .length_over(length_over), .length_unlimited(length_unlimited),
    .symbol_tick(symbol_tick), .tx_bit(tx_bit));
  serial_host_model host (.clk(clk), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .miso(miso));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic rd_check(input logic [5:0] a, input logic [7:0] exp);
    host.read_reg(a, rd);
    check($sformatf("reg %h", a), rd, exp);
  endtask
  // bounded wait; returns cycles from the call to the next tick
  task automatic wait_tick(output int n);
    n = 0;
    while (1) begin
      hold(1);
      n++;
      if (symbol_tick === 1'b1) break;
      if (n > 2000) begin
        err_count++;
        end_sim();
      end
    end
  endtask
  task automatic frame(input logic [7:0] len);
    length_byte = len;
    frame_start = 1'b1;
    hold(1);
    frame_start = 1'b0;
    hold(2);
  endtask
  task automatic reset_values();
    logic [5:0] a [11] = '{6'h05, 6'h06, 6'h08, 6'h09, 6'h0A, 6'h0D,
      6'h0E, 6'h0F, 6'h10, 6'h11, 6'h07};
    logic [7:0] v [11] = '{8'h91, 8'hFF, 8'h45, 8'h00, 8'h00, 8'h1E,
      8'hC4, 8'hEC, 8'h8C, 8'h22, 8'h00};
    check("sync", sync_low_word, 8'h91);
    check("white", whitening_on, 1'b1);
    check("lmode", length_mode, 2'b01);
    check("base_frequency_word", base_frequency_word, 24'h1EC4EC);
    for (int i = 0; i < 11; i++) rd_check(a[i], v[i]);
  endtask
  task automatic access_kinds();
    host.write_reg(6'h05, 8'h12);
    check("sync", sync_low_word, 8'h12);
    host.write_reg(6'h0D, 8'hFF);
    rd_check(6'h0D, 8'h3F);
    check("base_frequency_word top", base_frequency_word[23:22], 2'b00);
    host.write_reg(6'h10, 8'hFF);
    rd_check(6'h10, 8'h8F);
    host.write_reg(6'h07, 8'hAA);
    rd_check(6'h07, 8'h00);
    // legal length code only; unused bits stay zero
    host.write_reg(6'h08, 8'hFE);
    rd_check(6'h08, 8'h76);
    check("crc", crc_on, 1'b1);
    check("lmode", length_mode, 2'b10);
  endtask
  task automatic channel_burst();
    host.write_reg(6'h0D, 8'h10);
    host.write_reg(6'h0E, 8'h20);
    host.write_reg(6'h0F, 8'h30);
    host.write_reg(6'h0A, 8'h03);
    hold(1);
    check("base_frequency_word", base_frequency_word, 24'h102030);
    check("carrier", carrier_word, 25'h102330);
    host.sel(1'b1);
    host.xfer(8'h49, rd);
    host.xfer(8'h5A, rd);
    host.xfer(8'hFF, rd);
    host.sel(1'b0);
    check("addr", node_address, 8'h5A);
    check("channel_index", channel_index, 8'hFF);
    check("carrier", carrier_word, 25'h111F30);
  endtask
  task automatic rate_and_formats();
    int n;
    host.write_reg(6'h10, 8'h0F);
    host.write_reg(6'h11, 8'h00);
    wait_tick(n);
    wait_tick(n);
    // hidden one gives 2^23 per cycle, so a tick every 32 cycles
    check("tick gap", n, 32);
    for (int f = 0; f < 4; f++) begin
      host.write_reg(6'h08, {2'b00, f[1:0], 4'h0});
      check("fmt", tx_data_source_format, f[1:0]);
      check("white", whitening_on, 1'b0);
    end
    pin0 = 1'b1;
    hold(2);
    check("async", tx_bit, 1'b1);
    pin0 = 1'b0;
    hold(2);
    check("async", tx_bit, 1'b0);
    fifo_bit = 1'b1;
    for (int f = 0; f < 2; f++) begin
      host.write_reg(6'h08, {2'b00, f[1:0], 4'h0});
      wait_tick(n);
      hold(1);
      check("src bit", tx_bit, f == 0);
    end
    // whitening on: the first noise bits after restart are the seed's
    host.write_reg(6'h08, 8'h40);
    frame(8'h00);
    wait_tick(n);
    hold(1);
    check("whitened", tx_bit, fifo_bit ^ NOISE_SEED[0]);
  endtask
  task automatic lengths();
    host.write_reg(6'h06, 8'h20);
    host.write_reg(6'h08, 8'h00);
    frame(8'h10);
    check("len", packet_length, 8'h20);
    check("over", length_over, 1'b0);
    host.write_reg(6'h08, 8'h01);
    frame(8'h10);
    check("len", packet_length, 8'h10);
    frame(8'h30);
    check("over", length_over, 1'b1);
    host.write_reg(6'h08, 8'h02);
    frame(8'h10);
    check("unlim", length_unlimited, 1'b1);
    check("lmode", length_mode, 2'b10);
  endtask
  initial begin
    rst_n = 1'b0;
    fifo_bit = 1'b0;
    pin0 = 1'b0;
    frame_start = 1'b0;
    length_byte = 8'h00;
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    hold(2);
    reset_values();
    access_kinds();
    channel_burst();
    rate_and_formats();
    lengths();
    end_sim();
  end
endmodule
`default_nettype wire
